//--- atir_regs.v
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "atir_map.vh"
// Operation
// - overvoltage limit register, field [15:2], for aux channels 2 through 7
// - undervoltage limit register, field [15:2], for aux channels 3 through 7
// - limits are offset-binary codes spanning 0 V to 5 V
// - limit bits [1:0] reserved; host writes zero, device reads back zero
// - 64-bit lot identifier readable over eight byte locations
// - 16-bit serial identifier readable over two byte locations
// - 64-bit scratch area, host writable and readable, no other effect
// - limit field forms upper 14 bits of 16-bit compare value, low bits zero
module atir_regs #(
  parameter [63:0] LOT_ID = 64'h0123456789ABCDEF,
  parameter [15:0] SERIAL_ID = 16'h5A5A
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // aux conversion samples, channels 2..7, from converter logic
  input wire [95:0] aux_sample,
  input wire [5:0] aux_sample_valid,
  // fault flags and interrupt
  output reg [5:0] aux_high_fault,
  output reg [5:0] aux_low_fault,
  output reg irq
);
  // ==========================================================
  // helpers
  // ==========================================================
  // 16-bit comparison value from a stored limit register
  function [15:0] cmp_value;
    input [15:0] lim;
    begin
      cmp_value = {lim[`ATIR_LIMIT_MSB:`ATIR_LIMIT_LSB], 2'b00};
    end
  endfunction

  // word index from a byte address
  function [7:0] word_index;
    input [31:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  // scratch area spans two word indices
  function is_scratch;
    input [7:0] idx;
    begin
      is_scratch = (idx == `ATIR_IDX_SCRATCH) || (idx == `ATIR_IDX_SCRATCH + 8'h01);
    end
  endfunction

  // read word of a stored limit, spare bits returned as zero
  function [31:0] limit_word;
    input [15:0] lim;
    begin
      limit_word = {16'h0000, cmp_value(lim)};
    end
  endfunction

  // ==========================================================
  // limit storage: high[0..5]=aux2..7, low[1..5]=aux3..7
  // ==========================================================
  reg [15:0] high_lim [0:5];
  reg [15:0] low_lim [1:5];
  reg [`ATIR_STAT_W-1:0] status;
  reg [`ATIR_STAT_W-1:0] mask;

  // ==========================================================
  // write channel
  // ==========================================================
  reg aw_held;
  reg w_held;
  reg [7:0] aw_idx;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [7:0] aw_now = aw_held ? aw_idx : word_index(s_axi_awaddr);
  wire aw_have = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_have = w_held | (s_axi_wvalid & s_axi_wready);
  wire [31:0] wd_now = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws_now = w_held ? w_strb : s_axi_wstrb;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;

  reg wr_map_hit;
  reg wr_scratch;
  reg [2:0] wr_hi_sel;
  reg [2:0] wr_lo_sel;
  reg wr_mask;
  always @* begin
    wr_map_hit = 1'b1;
    wr_scratch = 1'b0;
    wr_hi_sel = 3'd7;
    wr_lo_sel = 3'd7;
    wr_mask = 1'b0;
    case (aw_now)
      `ATIR_IDX_AUX2_HIGH: wr_hi_sel = 3'd0;
      `ATIR_IDX_AUX3_HIGH: wr_hi_sel = 3'd1;
      `ATIR_IDX_AUX4_HIGH: wr_hi_sel = 3'd2;
      `ATIR_IDX_AUX5_HIGH: wr_hi_sel = 3'd3;
      `ATIR_IDX_AUX6_HIGH: wr_hi_sel = 3'd4;
      `ATIR_IDX_AUX7_HIGH: wr_hi_sel = 3'd5;
      `ATIR_IDX_AUX3_LOW: wr_lo_sel = 3'd1;
      `ATIR_IDX_AUX4_LOW: wr_lo_sel = 3'd2;
      `ATIR_IDX_AUX5_LOW: wr_lo_sel = 3'd3;
      `ATIR_IDX_AUX6_LOW: wr_lo_sel = 3'd4;
      `ATIR_IDX_AUX7_LOW: wr_lo_sel = 3'd5;
      `ATIR_IDX_SCRATCH, `ATIR_IDX_SCRATCH + 8'h01: wr_scratch = 1'b1;
      `ATIR_IDX_MASK: wr_mask = 1'b1;
      `ATIR_IDX_LOT, `ATIR_IDX_LOT + 8'h01, `ATIR_IDX_SERIAL, `ATIR_IDX_STATUS: begin
        wr_map_hit = 1'b1;
      end
      default: wr_map_hit = 1'b0;
    endcase
  end

  // merged limit write: reserved bits forced to zero on store
  wire [15:0] lim_wr = {ws_now[1] ? wd_now[15:8] : 8'h00,
                        ws_now[0] ? wd_now[7:0] : 8'h00} & 16'hFFFC;

  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ATIR_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      mask <= `ATIR_MASK_RESET;
      for (k = 0; k < 6; k = k + 1) begin
        high_lim[k] <= `ATIR_LIMIT_RESET;
      end
      for (k = 1; k < 6; k = k + 1) begin
        low_lim[k] <= `ATIR_LIMIT_RESET;
      end
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map_hit ? `ATIR_RESP_OKAY : `ATIR_RESP_SLVERR;
        if (wr_hi_sel != 3'd7 && ws_now[1:0] == 2'b11) begin
          high_lim[wr_hi_sel] <= lim_wr;
        end
        if (wr_lo_sel != 3'd7 && ws_now[1:0] == 2'b11) begin
          low_lim[wr_lo_sel] <= lim_wr;
        end
        if (wr_mask && ws_now[1:0] == 2'b11) begin
          mask <= wd_now[`ATIR_STAT_W-1:0];
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_idx <= word_index(s_axi_awaddr);
          s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
          s_axi_wready <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // scratch memory
  // ==========================================================
  wire [7:0] ar_idx = word_index(s_axi_araddr);
  wire [31:0] scratch_rd;
  atir_scratch_mem u_scratch (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(do_write & wr_scratch),
    .wr_addr(aw_now[0]),
    .wr_data(wd_now),
    .wr_strb(ws_now),
    .rd_addr(ar_idx[0]),
    .rd_data(scratch_rd)
  );

  // ==========================================================
  // read channel: address taken, data two cycles later
  // ==========================================================
  reg rd_pend;
  reg rd_scratch;
  reg [31:0] rd_word;
  reg rd_hit;
  reg rd_status;
  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    rd_status = 1'b0;
    case (ar_idx)
      `ATIR_IDX_AUX2_HIGH: rd_word = limit_word(high_lim[0]);
      `ATIR_IDX_AUX3_HIGH: rd_word = limit_word(high_lim[1]);
      `ATIR_IDX_AUX4_HIGH: rd_word = limit_word(high_lim[2]);
      `ATIR_IDX_AUX5_HIGH: rd_word = limit_word(high_lim[3]);
      `ATIR_IDX_AUX6_HIGH: rd_word = limit_word(high_lim[4]);
      `ATIR_IDX_AUX7_HIGH: rd_word = limit_word(high_lim[5]);
      `ATIR_IDX_AUX3_LOW: rd_word = limit_word(low_lim[1]);
      `ATIR_IDX_AUX4_LOW: rd_word = limit_word(low_lim[2]);
      `ATIR_IDX_AUX5_LOW: rd_word = limit_word(low_lim[3]);
      `ATIR_IDX_AUX6_LOW: rd_word = limit_word(low_lim[4]);
      `ATIR_IDX_AUX7_LOW: rd_word = limit_word(low_lim[5]);
      `ATIR_IDX_LOT: rd_word = LOT_ID[63:32];
      `ATIR_IDX_LOT + 8'h01: rd_word = LOT_ID[31:0];
      `ATIR_IDX_SERIAL: rd_word = {16'h0000, SERIAL_ID};
      `ATIR_IDX_SCRATCH, `ATIR_IDX_SCRATCH + 8'h01: rd_word = 32'h00000000;
      `ATIR_IDX_STATUS: begin
        rd_word = {20'h00000, status};
        rd_status = 1'b1;
      end
      `ATIR_IDX_MASK: rd_word = {20'h00000, mask};
      default: rd_hit = 1'b0;
    endcase
  end

  wire rd_take = s_axi_arvalid & s_axi_arready;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ATIR_RESP_OKAY;
      rd_pend <= 1'b0;
      rd_scratch <= 1'b0;
    end else begin
      rd_pend <= 1'b0;
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        rd_pend <= 1'b1;
        rd_scratch <= is_scratch(ar_idx);
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `ATIR_RESP_OKAY : `ATIR_RESP_SLVERR;
      end
      if (rd_pend) begin
        s_axi_rvalid <= 1'b1;
        if (rd_scratch) begin
          s_axi_rdata <= scratch_rd;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // fault detection and interrupt
  // ==========================================================
  wire [5:0] smp_valid;
  atir_sync #(.W(6)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(aux_sample_valid),
    .dout(smp_valid)
  );
  // sample words pass the same two stages as their strobes
  wire [95:0] smp_data;
  atir_sync #(.W(96)) u_sync_data (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(aux_sample),
    .dout(smp_data)
  );
  reg [5:0] valid_q;
  reg [5:0] next_high;
  reg [5:0] next_low;
  integer c;
  always @* begin
    next_high = aux_high_fault;
    next_low = aux_low_fault;
    for (c = 0; c < 6; c = c + 1) begin
      if (smp_valid[c] && !valid_q[c]) begin
        next_high[c] = smp_data[c*16 +: 16] > cmp_value(high_lim[c]);
        if (c != 0) begin
          next_low[c] = smp_data[c*16 +: 16] < cmp_value(low_lim[c]);
        end
      end
    end
    next_low[0] = 1'b0;
  end

  // ==========================================================
  // sticky status and interrupt
  // ==========================================================
  wire [`ATIR_STAT_W-1:0] events = {next_low & ~aux_low_fault, next_high & ~aux_high_fault};
  wire status_clr = rd_take & rd_status;
  // a fault event in the same cycle as the clearing read wins
  wire [`ATIR_STAT_W-1:0] next_status =
    (status_clr ? {`ATIR_STAT_W{1'b0}} : status) | events;
  always @(posedge aclk) begin
    if (!aresetn) begin
      valid_q <= 6'h00;
      aux_high_fault <= 6'h00;
      aux_low_fault <= 6'h00;
      status <= {`ATIR_STAT_W{1'b0}};
      irq <= 1'b0;
    end else begin
      valid_q <= smp_valid;
      aux_high_fault <= next_high;
      aux_low_fault <= next_low;
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end
endmodule // atir_regs

//--- atir_map.vh
`ifndef ATIR_MAP_VH
`define ATIR_MAP_VH
// register indices as printed (byte address = 4 * index)
`define ATIR_IDX_AUX2_HIGH 8'h9C
`define ATIR_IDX_AUX3_LOW 8'h9E
`define ATIR_IDX_AUX3_HIGH 8'hA0
`define ATIR_IDX_AUX4_LOW 8'hA2
`define ATIR_IDX_AUX4_HIGH 8'hA4
`define ATIR_IDX_AUX5_LOW 8'hA6
`define ATIR_IDX_AUX5_HIGH 8'hA8
`define ATIR_IDX_AUX6_LOW 8'hAA
`define ATIR_IDX_AUX6_HIGH 8'hAC
`define ATIR_IDX_AUX7_LOW 8'hAE
`define ATIR_IDX_AUX7_HIGH 8'hB0
`define ATIR_IDX_LOT 8'hBE
`define ATIR_IDX_SERIAL 8'hC6
`define ATIR_IDX_SCRATCH 8'hC8
`define ATIR_IDX_STATUS 8'hE0
`define ATIR_IDX_MASK 8'hE1
// limit field position
`define ATIR_LIMIT_MSB 15
`define ATIR_LIMIT_LSB 2
// reset values
`define ATIR_LIMIT_RESET 16'h0000
`define ATIR_SCRATCH_RESET 64'h0000000000000000
`define ATIR_MASK_RESET 12'h000
// status layout: bits [5:0] over aux2..7, bits [11:6] under aux2..7 (bit 6 unused)
`define ATIR_STAT_W 12
`define ATIR_OV_LSB 0
`define ATIR_UV_LSB 6
`define ATIR_RESP_OKAY 2'b00
`define ATIR_RESP_SLVERR 2'b10
`endif

//--- atir_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module atir_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // atir_sync

//--- atir_scratch_mem.v
`timescale 1ns/1ps
`include "atir_map.vh"
// two 32-bit scratch words, registered read, byte-lane writes
module atir_scratch_mem (
  input wire aclk,
  input wire aresetn,
  // write port
  input wire wr_en,
  input wire wr_addr,
  input wire [31:0] wr_data,
  input wire [3:0] wr_strb,
  // read port
  input wire rd_addr,
  output reg [31:0] rd_data
);
  reg [31:0] mem0;
  reg [31:0] mem1;
  integer i;
  wire [63:0] scratch_init = `ATIR_SCRATCH_RESET;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem0 <= scratch_init[31:0];
      mem1 <= scratch_init[63:32];
      rd_data <= 32'h00000000;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_en && wr_strb[i] && !wr_addr) begin
          mem0[i*8 +: 8] <= wr_data[i*8 +: 8];
        end
        if (wr_en && wr_strb[i] && wr_addr) begin
          mem1[i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
      rd_data <= rd_addr ? mem1 : mem0;
    end
  end
endmodule // atir_scratch_mem

//--- atir_regs_properties.sv
`timescale 1ns/1ps
`include "atir_map.vh"
// ==========
// port checks for the register bank
module atir_regs_properties (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // write side
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  // read side
  input logic [31:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // faults
  input logic [5:0] aux_low_fault
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] a_q;
  always @(posedge aclk) if (s_axi_arvalid && s_axi_arready) a_q <= s_axi_araddr;
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_arbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arbusy: assert property (p_arbusy) else $error("read taken while busy");
  property p_errzero;
    s_axi_rvalid && s_axi_rresp == `ATIR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_errzero: assert property (p_errzero) else $error("error read not zero");
  property p_nolow2;
    aux_low_fault[0] == 1'b0;
  endproperty
  a_nolow2: assert property (p_nolow2) else $error("aux2 low fault");
  property p_resv;
    s_axi_rvalid && s_axi_rresp == `ATIR_RESP_OKAY && a_q >= 32'h270 && a_q <= 32'h2C0
      |-> s_axi_rdata[1:0] == 2'b00 && s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("limit spare bits set");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `ATIR_RESP_SLVERR);
  c_lim: cover property (s_axi_rvalid && a_q == 32'h270);
endmodule // atir_regs_properties

//--- atir_host.sv
`timescale 1ns/1ps
// ==========
// axi4-lite master in the host's place
module atir_host (
  // clock
  input logic aclk,
  // write channels
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // released payload shows inverted value
  task automatic wr(input logic [31:0] a, v, input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, pb;
    pa = 1;
    pw = 1;
    pb = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw || pb) begin
      @(posedge aclk);
      if (pb && s_axi_bvalid) begin
        r = s_axi_bresp;
        pb = 0;
        s_axi_bready <= 1'b0;
      end
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~v;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    logic pa, pr;
    pa = 1;
    pr = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pr) begin
      @(posedge aclk);
      if (pa && s_axi_arready) begin
        pa = 0;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        pr = 0;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
endmodule // atir_host

//--- tb.sv
`timescale 1ns/1ps
`include "atir_map.vh"
// ==========
// register bank testbench
module tb;
  localparam [63:0] LOT = 64'hC0FFEE0012345678; // arbitrary
  localparam [15:0] SER = 16'h3C5A; // arbitrary
  localparam int L0 = 4 * `ATIR_IDX_AUX2_HIGH;
  localparam int SC = 4 * `ATIR_IDX_SCRATCH;
  localparam int ST = 4 * `ATIR_IDX_STATUS;
  localparam [1:0] OK = `ATIR_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [95:0] aux_sample = '0;
  logic [5:0] aux_sample_valid = '0;
  logic [5:0] aux_high_fault, aux_low_fault;
  logic irq;
  int n_errors = 0;
  int checks_done = 0;
  always #5 aclk = ~aclk;
  atir_regs #(.LOT_ID(LOT), .SERIAL_ID(SER)) dut_u (.*);
  atir_host h (.*);
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rc(input logic [31:0] a, e, input logic [1:0] re);
    h.rd(a, d, r);
    chk(d, e);
    chk(r, re);
  endtask
  task wc(input logic [31:0] a, v, input logic [3:0] s, input logic [1:0] re);
    h.wr(a, v, s, r);
    chk(r, re);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rc(L0 + 8 * i, 0, OK);
    rc(4 * `ATIR_IDX_MASK, 0, OK);
    rc(L0 + 4, 0, `ATIR_RESP_SLVERR);
    wc(L0 + 4, 32'hFFFF, 4'hF, `ATIR_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 11; i++) wc(L0 + 8 * i, 32'hFFFF1230 + 32'h104 * i, 4'hF, OK);
    for (int i = 0; i < 11; i++) rc(L0 + 8 * i, (32'h1230 + 32'h104 * i) & 32'hFFFC, OK);
    wc(L0, 32'hFFFC, 4'h1, OK);
    rc(L0, 32'h1230, OK);
    $display("test limits done");
    wc(4 * `ATIR_IDX_LOT, 32'h0, 4'hF, OK);
    rc(4 * `ATIR_IDX_LOT, LOT[63:32], OK);
    rc(4 * `ATIR_IDX_LOT + 4, LOT[31:0], OK);
    rc(4 * `ATIR_IDX_SERIAL, {16'h0, SER}, OK);
    $display("test identity done");
    wc(SC, 32'hDEADBEEF, 4'hF, OK);
    wc(SC + 4, 32'h01234567, 4'hF, OK);
    wc(SC, 32'h00AA0000, 4'h4, OK);
    rc(SC, 32'hDEAABEEF, OK);
    rc(SC + 4, 32'h01234567, OK);
    $display("test scratch done");
    wc(L0, 32'h1000, 4'hF, OK);
    wc(L0 + 8, 32'h2000, 4'hF, OK);
    wc(4 * `ATIR_IDX_MASK, 32'h001, 4'hF, OK);
    aux_sample <= {64'h0, 16'h1400, 16'h1002};
    @(posedge aclk);
    aux_sample_valid <= 6'h03;
    for (int k = 0; k < 20 && irq !== 1'b1; k++) @(posedge aclk);
    chk(aux_high_fault, 6'h01);
    chk(aux_low_fault, 6'h02);
    chk(irq, 1'b1);
    rc(ST, 32'h081, OK);
    chk(irq, 1'b0);
    rc(ST, 32'h0, OK);
    $display("test faults done");
    summarize;
  end
endmodule // tb
bind atir_regs atir_regs_properties chk_u (.*);
